/* File: logic/ccu_pkg.sv */
// Constants, register map and carrier types of the capture/compare/PWM unit.
// Assumes one 50 MHz clock and a plain address/strobe register port.
// Contract
// - Capture edge prescaler clears when disabled, outside capture mode and on reset.
// - Moving between capture prescaler settings keeps the prescaler count.
// - Compare mode matches value to time base, acts on pin, sets flag.
// - Zero in the control register forces the compare output latch low.
// - Software interrupt compare sets the flag and leaves the pin alone.
// - Special trigger in the first unit resets the capture time base.
// - Special trigger in the second unit also starts a conversion if enabled.
// - Special trigger counter reset never sets the overflow flag.
// - PWM mode drives a waveform with up to ten bits of duty.
// - Zero in the control register forces the PWM output latch low.
// - PWM period is limit plus one, times four clocks, times prescale.
// - Limit match: clear time base, set pin unless duty zero, load shadow.
// - Postscaler only paces the period flag, never the PWM period.
// - Duty is low duty byte above control bits five and four.
// - Duty writes allowed anytime, applied after period match; shadow read-only.
// - Duty is double-buffered in shadow plus two-bit latch.
// - Pin clears when shadow and latch equal extended PWM time base.
// - Duty beyond the period never clears the pin.
// - Mode bits decode off, four capture, four compare and PWM modes.
// - Capture copies the time base into the value and sets the flag.
package ccu_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_VALL = 4'h1;
  localparam logic [3:0] OFF_VALH = 4'h2;
  localparam logic [3:0] OFF_PERIOD = 4'h3;
  localparam logic [3:0] OFF_PWMCTL = 4'h4;
  localparam logic [3:0] OFF_TBL = 4'h5;
  localparam logic [3:0] OFF_TBH = 4'h6;
  localparam logic [3:0] OFF_FLAGS = 4'h7;
  localparam logic [3:0] OFF_PWMTB = 4'h8;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_DLSB_HI = 5;
  localparam int CTRL_DLSB_LO = 4;
  localparam int PWMCTL_RUN_TB = 7;
  localparam int PWMCTL_POST_HI = 6;
  localparam int PWMCTL_POST_LO = 3;
  localparam int PWMCTL_EN = 2;
  localparam int FLG_UNIT = 0;
  localparam int FLG_OVF = 1;
  localparam int FLG_PER = 2;
  localparam int FLG_IE = 3;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // ****************************************
  // Timing: four clocks make one instruction cycle
  // ****************************************
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  // Mode bits of the control register
  typedef enum logic [3:0] {
    CCU_OFF = 4'b0000,
    CCU_CAP_FALL = 4'b0100,
    CCU_CAP_RISE = 4'b0101,
    CCU_CAP_R4 = 4'b0110,
    CCU_CAP_R16 = 4'b0111,
    CCU_CMP_SET = 4'b1000,
    CCU_CMP_CLR = 4'b1001,
    CCU_CMP_SWI = 4'b1010,
    CCU_CMP_SPEC = 4'b1011
  } ccuMode_t;

  // One register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ccuBusReq_t;

endpackage

/* File: logic/ccu_sync.sv */
// Two-flop synchroniser for the unit pin.
// Assumes an asynchronous pin and the internally released reset.
`timescale 1ns/100ps
`default_nettype none
module ccu_sync
  import ccu_pkg::*;
(
  input wire logic mclk,
  input wire logic rstN,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // First stage feeds only the second, to contain metastability
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: logic/ccu_pwm_base.sv */
// Eight-bit period counter with 1/4/16 prescaler for the PWM time base.
// Assumes instTick pulses once per four clocks from the owning unit.
`timescale 1ns/100ps
`default_nettype none
module ccu_pwm_base
  import ccu_pkg::*;
(
  input wire logic mclk,
  input wire logic rstN,
  input wire logic ce,
  input wire logic instTick,
  input wire logic [1:0] quarter,
  input wire logic run,
  input wire logic [1:0] prescale,
  input wire logic [7:0] period,
  output logic [7:0] tb_q,
  output logic [1:0] ext,
  output logic wrap
);

  logic [3:0] pre_q;
  logic preHit;
  logic step;

  // Prescale select: 00 by 1, 01 by 4, 1x by 16
  assign preHit = (prescale == 2'b00) ? 1'b1 :
                  (prescale == 2'b01) ? (pre_q[1:0] == 2'b11) : (pre_q == 4'hF);
  assign step = instTick && run && preHit;
  assign wrap = step && (tb_q == period);
  // Fine bits below the counter, giving Tosc-scaled duty resolution
  assign ext = (prescale == 2'b00) ? quarter :
               (prescale == 2'b01) ? pre_q[1:0] : pre_q[3:2];

  // Period is (limit+1) steps of 4 clocks times prescale
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pre_q <= 4'h0;
      tb_q <= 8'h00;
    end else if (ce) begin
      if (!run) begin
        pre_q <= 4'h0;
      end else if (instTick) begin
        pre_q <= pre_q + 4'h1;
      end
      if (step) begin
        tb_q <= (tb_q == period) ? 8'h00 : tb_q + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: logic/ccu_unit.sv */
// Capture/compare/PWM unit with its capture time base and PWM time base.
// Assumes a single-cycle register port and an asynchronous unit pin.
`timescale 1ns/100ps
`default_nettype none
module ccu_unit
  import ccu_pkg::*;
#(
  parameter logic UNIT_SECOND = 1'b0
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire ccuBusReq_t busReq,
  output logic [7:0] rdData_q,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic unitFlag,
  output logic unitIe,
  input wire logic adcEnable,
  output logic adcStart_q
);

  // ****************************************
  // Reset release and pin input
  // ****************************************
  logic [1:0] rstPipe_q;
  logic rstN;
  logic pinSync;
  logic pinPrev_q;

  // Release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_q <= 2'b00;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  ccu_sync uPinSync (
    .mclk(mclk),
    .rstN(rstN),
    .ce(ce),
    .d(pinIn),
    .q(pinSync)
  );

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] valL_q;
  logic [7:0] valH_q;
  logic [7:0] period_q;
  logic [7:0] pwmCtl_q;
  logic [15:0] tb_q;
  logic unitFlag_q;
  logic ovfFlag_q;
  logic perFlag_q;
  logic ie_q;
  logic [3:0] mode;
  logic wrCtrl, wrValL, wrValH, wrPeriod, wrPwmCtl, wrTbl, wrTbh, wrFlags;

  assign wrCtrl = busReq.we && (busReq.addr == OFF_CTRL);
  assign wrValL = busReq.we && (busReq.addr == OFF_VALL);
  assign wrValH = busReq.we && (busReq.addr == OFF_VALH);
  assign wrPeriod = busReq.we && (busReq.addr == OFF_PERIOD);
  assign wrPwmCtl = busReq.we && (busReq.addr == OFF_PWMCTL);
  assign wrTbl = busReq.we && (busReq.addr == OFF_TBL);
  assign wrTbh = busReq.we && (busReq.addr == OFF_TBH);
  assign wrFlags = busReq.we && (busReq.addr == OFF_FLAGS);

  // Mode groups
  logic modeOff, isCapture, isCompare, isPwm;
  assign mode = ctrl_q[3:0];
  assign modeOff = (mode == CCU_OFF);
  assign isCapture = (mode[3:2] == 2'b01);
  assign isCompare = (mode[3:2] == 2'b10);
  assign isPwm = (mode[3:2] == 2'b11);

  // ****************************************
  // Instruction-cycle tick
  // ****************************************
  logic [1:0] quarter_q;
  logic instTick;
  assign instTick = (quarter_q == QUARTER_LAST);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      quarter_q <= 2'b00;
    end else if (ce) begin
      quarter_q <= quarter_q + 2'b01;
    end
  end

  // ****************************************
  // Capture
  // ****************************************
  logic [3:0] capCnt_q;
  logic riseEdge, fallEdge, capEvent;
  assign riseEdge = pinSync && !pinPrev_q;
  assign fallEdge = !pinSync && pinPrev_q;
  assign capEvent = isCapture && ((mode == CCU_CAP_FALL) ? fallEdge :
                    (mode == CCU_CAP_RISE) ? riseEdge :
                    (mode == CCU_CAP_R4) ? (riseEdge && capCnt_q[1:0] == 2'b11) :
                    (riseEdge && capCnt_q == 4'hF));

  // Count keeps running across capture-to-capture mode changes
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinPrev_q <= 1'b0;
      capCnt_q <= 4'h0;
    end else if (ce) begin
      pinPrev_q <= pinSync;
      if (!isCapture) begin
        capCnt_q <= 4'h0;
      end else if (riseEdge) begin
        capCnt_q <= capCnt_q + 4'h1;
      end
    end
  end

  // ****************************************
  // Compare and special event
  // ****************************************
  logic matchPrev_q;
  logic cmpLatch_q;
  logic matchNow, matchRise, specReset, tbStep, ovfSet, tbWrite;
  assign matchNow = isCompare && (tb_q == {valH_q, valL_q});
  // A match spans four clocks; act once on its first one
  assign matchRise = matchNow && !matchPrev_q;
  assign specReset = matchRise && (mode == CCU_CMP_SPEC);
  assign tbWrite = wrTbl || wrTbh;
  assign tbStep = pwmCtl_q[PWMCTL_RUN_TB] && instTick;
  // Overflow only from counting; trigger reset takes precedence
  assign ovfSet = tbStep && !specReset && !tbWrite && (tb_q == 16'hFFFF);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      matchPrev_q <= 1'b0;
      cmpLatch_q <= 1'b0;
    end else if (ce) begin
      matchPrev_q <= matchNow;
      if (modeOff) begin
        cmpLatch_q <= 1'b0;
      end else if (matchRise && mode == CCU_CMP_SET) begin
        cmpLatch_q <= 1'b1;
      end else if (matchRise && mode == CCU_CMP_CLR) begin
        cmpLatch_q <= 1'b0;
      end
    end
  end

  // Capture time base; writes beat the trigger reset
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      tb_q <= 16'h0000;
    end else if (ce) begin
      if (wrTbl) begin
        tb_q[7:0] <= busReq.wdata;
      end else if (wrTbh) begin
        tb_q[15:8] <= busReq.wdata;
      end else if (specReset) begin
        tb_q <= 16'h0000;
      end else if (tbStep) begin
        tb_q <= tb_q + 16'h0001;
      end
    end
  end

  // Conversion start pulse from the second unit only
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      adcStart_q <= 1'b0;
    end else if (ce) begin
      adcStart_q <= UNIT_SECOND && specReset && adcEnable;
    end
  end

  // ****************************************
  // PWM
  // ****************************************
  logic [7:0] pwmTb;
  logic [1:0] pwmExt;
  logic pwmWrap;
  logic [1:0] dutyLat_q;
  logic pwmLatch_q;
  logic [3:0] postCnt_q;
  logic dutyHit;
  logic [9:0] dutyNext;

  ccu_pwm_base uPwmBase (
    .mclk(mclk),
    .rstN(rstN),
    .ce(ce),
    .instTick(instTick),
    .quarter(quarter_q),
    .run(pwmCtl_q[PWMCTL_EN]),
    .prescale(pwmCtl_q[1:0]),
    .period(period_q),
    .tb_q(pwmTb),
    .ext(pwmExt),
    .wrap(pwmWrap)
  );

  assign dutyNext = {valL_q, ctrl_q[CTRL_DLSB_HI:CTRL_DLSB_LO]};
  // Duty above the period never meets the counter, so pin stays high
  assign dutyHit = ({valH_q, dutyLat_q} == {pwmTb, pwmExt});

  // Output latch: wrap sets, buffered duty clears
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pwmLatch_q <= 1'b0;
      dutyLat_q <= 2'b00;
    end else if (ce) begin
      if (pwmWrap && isPwm) begin
        dutyLat_q <= dutyNext[1:0];
      end
      if (!isPwm) begin
        pwmLatch_q <= 1'b0;
      end else if (pwmWrap) begin
        pwmLatch_q <= (dutyNext != 10'h000);
      end else if (dutyHit) begin
        pwmLatch_q <= 1'b0;
      end
    end
  end

  // Postscaler paces only the period flag
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      postCnt_q <= 4'h0;
    end else if (ce && pwmWrap) begin
      postCnt_q <= (postCnt_q == pwmCtl_q[PWMCTL_POST_HI:PWMCTL_POST_LO]) ?
                   4'h0 : postCnt_q + 4'h1;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic postHit;
  assign postHit = pwmWrap &&
                   (postCnt_q == pwmCtl_q[PWMCTL_POST_HI:PWMCTL_POST_LO]);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ctrl_q <= ZERO_RST;
      period_q <= PERIOD_RST;
      pwmCtl_q <= ZERO_RST;
    end else if (ce) begin
      if (wrCtrl) begin
        ctrl_q <= {2'b00, busReq.wdata[5:0]};
      end
      if (wrPeriod) begin
        period_q <= busReq.wdata;
      end
      if (wrPwmCtl) begin
        pwmCtl_q <= busReq.wdata;
      end
    end
  end

  // Value pair: capture wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      valL_q <= ZERO_RST;
      valH_q <= ZERO_RST;
    end else if (ce) begin
      if (capEvent) begin
        {valH_q, valL_q} <= tb_q;
      end else begin
        if (wrValL) begin
          valL_q <= busReq.wdata;
        end
        if (isPwm && pwmWrap) begin
          valH_q <= valL_q;
        end else if (wrValH && !isPwm) begin
          valH_q <= busReq.wdata;
        end
      end
    end
  end

  // Flags: hardware set beats a write-one clear
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      unitFlag_q <= 1'b0;
      ovfFlag_q <= 1'b0;
      perFlag_q <= 1'b0;
      ie_q <= 1'b0;
    end else if (ce) begin
      unitFlag_q <= (capEvent || matchRise) ||
                    (unitFlag_q && !(wrFlags && busReq.wdata[FLG_UNIT]));
      ovfFlag_q <= ovfSet || (ovfFlag_q && !(wrFlags && busReq.wdata[FLG_OVF]));
      perFlag_q <= postHit || (perFlag_q && !(wrFlags && busReq.wdata[FLG_PER]));
      if (wrFlags) begin
        ie_q <= busReq.wdata[FLG_IE];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] rdMux;
  assign rdMux = (busReq.addr == OFF_CTRL) ? ctrl_q :
                 (busReq.addr == OFF_VALL) ? valL_q :
                 (busReq.addr == OFF_VALH) ? valH_q :
                 (busReq.addr == OFF_PERIOD) ? period_q :
                 (busReq.addr == OFF_PWMCTL) ? pwmCtl_q :
                 (busReq.addr == OFF_TBL) ? tb_q[7:0] :
                 (busReq.addr == OFF_TBH) ? tb_q[15:8] :
                 (busReq.addr == OFF_FLAGS) ?
                   {4'h0, ie_q, perFlag_q, ovfFlag_q, unitFlag_q} :
                 (busReq.addr == OFF_PWMTB) ? pwmTb : 8'h00;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdData_q <= 8'h00;
    end else if (ce && busReq.re) begin
      rdData_q <= rdMux;
    end
  end

  // Pin drive follows the active mode; a duty match drops the PWM pin in its own cycle
  assign pinOut = isPwm ? (pwmLatch_q && !dutyHit) : cmpLatch_q;
  assign pinOe = isPwm || (isCompare && !mode[1]);
  assign unitFlag = unitFlag_q;
  assign unitIe = ie_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  sequence wrapSeq;
    ce && isPwm && pwmWrap && !capEvent;
  endsequence

  sequence specSeq;
    ce && specReset && !tbWrite;
  endsequence

  cap_clear_a: assert property (ce && !isCapture |=> capCnt_q == 4'h0)
    else $error("capture prescaler not cleared");
  cmp_set_a: assert property (ce && matchRise && mode == CCU_CMP_SET && !wrCtrl
    |=> cmpLatch_q && unitFlag_q)
    else $error("compare set action missing");
  off_cmp_a: assert property (ce && modeOff |=> !cmpLatch_q)
    else $error("compare latch not low when off");
  off_pwm_a: assert property (ce && modeOff |=> !pwmLatch_q && !pinOut)
    else $error("pwm latch not low when off");
  swi_pin_a: assert property (ce && matchRise && mode == CCU_CMP_SWI
    |=> $stable(cmpLatch_q))
    else $error("software interrupt moved the pin");
  spec_zero_a: assert property (specSeq |=> tb_q == 16'h0000)
    else $error("trigger did not zero time base");
  adc_pulse_a: assert property (specSeq and (UNIT_SECOND && adcEnable)
    |=> adcStart_q)
    else $error("conversion start missing");
  spec_ovf_a: assert property (specSeq and !wrFlags
    |=> ovfFlag_q == $past(ovfFlag_q))
    else $error("trigger touched overflow flag");
  wrap_load_a: assert property (wrapSeq |=> valH_q == $past(valL_q) && pwmTb == 8'h00)
    else $error("period wrap did not load shadow");
  shadow_ro_a: assert property (ce && isPwm && wrValH && !pwmWrap && !capEvent
    |=> $stable(valH_q))
    else $error("shadow written in pwm mode");
  duty_clr_a: assert property (ce && isPwm && !pwmWrap && dutyHit && !wrCtrl
    |=> !pwmLatch_q)
    else $error("pin not cleared at duty");
  cap_copy_a: assert property (ce && capEvent
    |=> {valH_q, valL_q} == $past(tb_q) && unitFlag_q)
    else $error("capture value or flag wrong");

endmodule
`default_nettype wire

/* File: verif/ccu_pin_model.sv */
// Far-side model of the unit pin: an external edge source with a pull-down.
// Assumes the bench calls pulses() from its main sequence.
`timescale 1ns/100ps
`default_nettype none
module ccu_pin_model (
  input wire logic mclk,
  input wire logic pinOut,
  input wire logic pinOe,
  output logic pinIn
);
  logic extLevel = 1'b0;

  // Wire level: the unit wins while it drives, else the external source
  assign pinIn = pinOe ? pinOut : extLevel;

  // Whole pulses, four clocks up and four down, so the sync never misses one
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      extLevel <= 1'b1;
      repeat (4) @(posedge mclk);
      extLevel <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/capture_compare_pwm_unit_bench.sv */
// Self-checking bench of the capture/compare/PWM unit, second-unit flavour.
// Assumes the pin model ccu_pin_model and a 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module capture_compare_pwm_unit_bench
  import ccu_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic adcEnable = 1'b0;
  ccuBusReq_t busReq = '0;
  logic [7:0] rdData_q;
  logic pinIn, pinOut, pinOe, unitFlag, unitIe, adcStart_q;
  logic reD1 = 1'b0;
  logic [7:0] expQ[$];
  logic [7:0] cmpMode[4] = '{8'h08, 8'h09, 8'h08, 8'h0A};
  logic cmpPin[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h0000_3b86;

  ccu_unit #(.UNIT_SECOND(1'b1)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .busReq(busReq), .rdData_q(rdData_q),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .unitFlag(unitFlag),
    .unitIe(unitIe), .adcEnable(adcEnable), .adcStart_q(adcStart_q)
  );
  ccu_pin_model pinSide (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  // ****
  // Clock, hang guard and read checker
  // ****
  initial begin
    forever #10 mclk = ~mclk;
  end

  // The slowest PWM case needs about two thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  // Read data appear in the cycle after the strobe and hold until the next read, so look there
  always @(posedge mclk) begin
    reD1 <= busReq.re;
    if (reD1) begin
      chk("rdData", {8'h00, expQ.pop_front()}, {8'h00, rdData_q});
    end
  end

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    busReq.we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge mclk);
    busReq <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    busReq.re <= 1'b0;
  endtask

  task automatic waitFlag();
    int n;
    n = 0;
    while (unitFlag !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk("unitFlag", 16'h0001, {15'h0, unitFlag});
  endtask

  function automatic logic pick(input int s);
    return s ? adcStart_q : pinOut;
  endfunction

  // High cycles and rising edges of one output over a window
  task automatic measure(input int s, input int len, output int hi, output int rises);
    logic prev;
    hi = 0;
    rises = 0;
    @(negedge mclk);
    prev = pick(s);
    repeat (len) begin
      @(negedge mclk);
      hi += (pick(s) === 1'b1);
      rises += (pick(s) === 1'b1 && prev === 1'b0);
      prev = pick(s);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    int hi, rises, per, pre, fac, pclk, duty;
    logic [9:0] dv;
    logic [3:0] m;
    logic [31:0] rnd;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(OFF_PERIOD, 8'hFF);
    rd(OFF_CTRL, 8'h00);
    rd(4'hF, 8'h00);
    wr(OFF_FLAGS, 8'h08);
    @(negedge mclk);
    chk("unitIe", 16'h0001, {15'h0, unitIe});
    wr(OFF_FLAGS, 8'h00);
    // Every mode code: reserved bits drop, pin driven only in output modes
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      wr(OFF_CTRL, {4'hC, m});
      rd(OFF_CTRL, {4'h0, m});
      @(negedge mclk);
      chk("pinOe", {15'h0, m[3] & (m[2] | ~m[1])}, {15'h0, pinOe});
    end
    // Clock enable low: a write taken then must leave no trace
    @(posedge mclk);
    ce <= 1'b0;
    wr(OFF_PERIOD, 8'h5A);
    ce <= 1'b1;
    rd(OFF_PERIOD, 8'hFF);
    $display("test mode decode done");
    // Capture with the time base frozen, so the copied value is known
    wr(OFF_PWMCTL, 8'h00);
    for (int i = 4; i < 6; i++) begin
      wr(OFF_CTRL, i[7:0]);
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_TBH, 8'h12);
      wr(OFF_TBL, i[7:0]);
      pinSide.pulses(1);
      repeat (6) @(posedge mclk);
      chk("unitFlag", 16'h0001, {15'h0, unitFlag});
      rd(OFF_VALL, i[7:0]);
      rd(OFF_VALH, 8'h12);
    end
    // Prescaled capture: off clears the partial count, a direct switch keeps it
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, 8'h06);
    wr(OFF_FLAGS, 8'h07);
    pinSide.pulses(3);
    chk("unitFlag", 16'h0000, {15'h0, unitFlag});
    pinSide.pulses(1);
    chk("unitFlag", 16'h0001, {15'h0, unitFlag});
    wr(OFF_FLAGS, 8'h07);
    pinSide.pulses(2);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, 8'h06);
    wr(OFF_FLAGS, 8'h07);
    pinSide.pulses(3);
    chk("unitFlag", 16'h0000, {15'h0, unitFlag});
    wr(OFF_CTRL, 8'h07);
    wr(OFF_FLAGS, 8'h07);
    pinSide.pulses(12);
    chk("unitFlag", 16'h0000, {15'h0, unitFlag});
    pinSide.pulses(1);
    chk("unitFlag", 16'h0001, {15'h0, unitFlag});
    $display("test capture done");
    // Compare set, clear, set, then software interrupt leaves the pin high
    wr(OFF_CTRL, 8'h00);
    wr(OFF_VALL, 8'h05);
    wr(OFF_VALH, 8'h00);
    wr(OFF_PWMCTL, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL, cmpMode[i]);
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_TBH, 8'h00);
      wr(OFF_TBL, 8'h00);
      waitFlag();
      chk("pinOut", {15'h0, cmpPin[i]}, {15'h0, pinOut});
    end
    wr(OFF_CTRL, 8'h00);
    // The latch follows the cleared mode one clock later
    repeat (2) @(negedge mclk);
    chk("pinOut", 16'h0000, {15'h0, pinOut});
    // Special trigger: a value of three wraps every twelve clocks, conversion start gated
    wr(OFF_VALL, 8'h03);
    for (int i = 0; i < 2; i++) begin
      adcEnable <= i[0];
      wr(OFF_CTRL, 8'h0B);
      wr(OFF_TBH, 8'h00);
      wr(OFF_TBL, 8'h00);
      wr(OFF_FLAGS, 8'h07);
      measure(1, 144, hi, rises);
      chk("adcStart", 16'(12 * i), 16'(rises));
      rd(OFF_TBH, 8'h00);
      rd(OFF_FLAGS, 8'h01);
    end
    wr(OFF_CTRL, 8'h00);
    $display("test compare done");
    // PWM: rising period limits keep the time base below each new limit
    for (int i = 0; i < 6; i++) begin
      per = i + 1;
      rnd = $random(seed);
      pre = rnd[9:8] % 3;
      fac = (pre == 0) ? 1 : (pre == 1) ? 4 : 16;
      pclk = (per + 1) * 4 * fac;
      duty = rnd[7:0] % (4 * per + 8);
      if (i == 0) duty = 0;
      if (i == 5) duty = 4 * per + 4;
      dv = duty[9:0];
      wr(OFF_PERIOD, per[7:0]);
      wr(OFF_VALL, dv[9:2]);
      wr(OFF_CTRL, {2'b00, dv[1:0], 4'h0});
      wr(OFF_PWMCTL, {1'b0, rnd[15:12], 1'b1, pre[1:0]});
      wr(OFF_CTRL, {2'b00, dv[1:0], 4'hC});
      repeat (2 * pclk + 8) @(posedge mclk);
      measure(0, 2 * pclk, hi, rises);
      if (duty >= 4 * (per + 1)) begin
        chk("pwmHigh", 16'(2 * pclk), 16'(hi));
        chk("pwmRises", 16'h0000, 16'(rises));
      end else begin
        chk("pwmHigh", 16'(2 * duty * fac), 16'(hi));
        chk("pwmRises", (duty == 0) ? 16'h0000 : 16'h0002, 16'(rises));
      end
      wr(OFF_VALH, 8'h55);
      rd(OFF_VALH, dv[9:2]);
    end
    wr(OFF_CTRL, 8'h00);
    @(negedge mclk);
    chk("pinOut", 16'h0000, {15'h0, pinOut});
    $display("test pwm done");
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
